// ==== design/dcbm_pkg.sv ====
package dcbm_pkg;
    localparam int DATA_W = 36;
    localparam int DEF_DEPTH = 1024;
    localparam int MAX_DEPTH = 32768;
    localparam int OFS_W = 15;
    localparam int CNT_W = 16;
    localparam logic [1:0] FT_RCLK_EDGES = 2'h3;
    // event pins (edges detected)
    localparam int EV_WCLK = 0;
    localparam int EV_WR = 1;
    localparam int EV_RCLK = 2;
    localparam int EV_RD = 3;
    // level pins
    localparam int CTL_WEN_N = 4;
    localparam int CTL_REN_N = 5;
    localparam int CTL_OE_N = 6;
    localparam int CTL_MRS_N = 7;
    localparam int CTL_PRS_N = 8;
    localparam int CTL_RT_N = 9;
    localparam int CTL_RM = 10;
    localparam int CTL_PFM = 11;
    localparam int CTL_IW = 12;
    localparam int CTL_OW = 13;
    localparam int CTL_BM = 14;
    localparam int CTL_BE = 15;
    localparam int CTL_FTSI = 16;
    localparam int CTL_SEN_N = 17;
    localparam int CTL_LD_N = 18;
    localparam int CTL_FS0 = 19;
    localparam int CTL_FS1 = 20;
    localparam int CTL_ASYW = 21;
    localparam int CTL_ASYR = 22;
    localparam int PIN_N = 23;
    typedef enum logic [1:0] {DCBM_W36, DCBM_W18, DCBM_W9} dcbm_width_e;
    // preset almost-flag offsets, picked by {sel1, sel0, load}
    localparam logic [OFS_W-1:0] DEF_OFS [8] = '{
        15'h0007, 15'h000f, 15'h001f, 15'h003f,
        15'h007f, 15'h00ff, 15'h01ff, 15'h03ff};
    localparam logic [DATA_W-1:0] DOUT_RST = 36'h000000000;
endpackage

// ==== design/dcbm_pin_if.sv ====
`timescale 1ns/10ps
// synchronised pin levels and their rising edges
interface dcbm_pin_if #(parameter int W = 1);
    logic [W-1:0] level;
    logic [W-1:0] rise;
    modport drv (output level, output rise);
    modport use_side (input level, input rise);
endinterface

// ==== design/dcbm_pin_sync.sv ====
`timescale 1ns/10ps
module dcbm_pin_sync #(
    parameter int W = 1
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [W-1:0] PIN,
    dcbm_pin_if.drv SYNC
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // two-flop synchroniser, third flop for edge detection
    always_ff @(posedge CLK) begin
        if (SRST) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= PIN;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign SYNC.level = stage2;
    assign SYNC.rise = stage2 & ~stage3;
endmodule

// ==== design/dcbm_fifo.sv ====
`timescale 1ns/10ps
module dcbm_fifo #(
    parameter int DEPTH = dcbm_pkg::DEF_DEPTH
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic WRITE_CLK,
    input wire logic WRITE_STROBE,
    input wire logic WRITE_ENABLE_N,
    input wire logic [35:0] WRITE_DATA_IN,
    input wire logic READ_CLK,
    input wire logic READ_STROBE,
    input wire logic READ_ENABLE_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic MASTER_RESET_N,
    input wire logic PARTIAL_RESET_N,
    input wire logic RETRANSMIT_N,
    input wire logic RETRANSMIT_LATENCY_SEL,
    input wire logic FLAG_TIMING_SEL,
    input wire logic INPUT_WIDTH_SEL,
    input wire logic OUTPUT_WIDTH_SEL,
    input wire logic BUS_MATCHING_SEL,
    input wire logic BIG_ENDIAN_SEL,
    input wire logic FALLTHROUGH_SEL_SERIAL_IN,
    input wire logic SERIAL_ENABLE_N,
    input wire logic LOAD_N,
    input wire logic FLAG_SEL0,
    input wire logic FLAG_SEL1,
    input wire logic ASYNC_WRITE_SEL,
    input wire logic ASYNC_READ_SEL,
    output logic [35:0] READ_DATA_OUT,
    output logic READ_DATA_OUT_OE,
    output logic EMPTY_FLAG_N,
    output logic FULL_FLAG_N,
    output logic HALF_FULL_FLAG_N,
    output logic ALMOST_EMPTY_FLAG_N,
    output logic ALMOST_FULL_FLAG_N
);
    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam int CW = dcbm_pkg::CNT_W;
    localparam int OW = dcbm_pkg::OFS_W;

    dcbm_pin_if #(.W(dcbm_pkg::PIN_N)) pins ();
    dcbm_pin_if #(.W(dcbm_pkg::DATA_W)) din ();
    logic [dcbm_pkg::PIN_N-1:0] pin_vec;

    assign pin_vec = {ASYNC_READ_SEL, ASYNC_WRITE_SEL, FLAG_SEL1, FLAG_SEL0,
        LOAD_N, SERIAL_ENABLE_N, FALLTHROUGH_SEL_SERIAL_IN, BIG_ENDIAN_SEL,
        BUS_MATCHING_SEL, OUTPUT_WIDTH_SEL, INPUT_WIDTH_SEL, FLAG_TIMING_SEL,
        RETRANSMIT_LATENCY_SEL, RETRANSMIT_N, PARTIAL_RESET_N,
        MASTER_RESET_N, OUTPUT_ENABLE_N, READ_ENABLE_N, WRITE_ENABLE_N,
        READ_STROBE, READ_CLK, WRITE_STROBE, WRITE_CLK};

    // every pin crosses two flops before use
    dcbm_pin_sync #(.W(dcbm_pkg::PIN_N)) u_pin_sync (
        .CLK(CLK), .SRST(SRST), .PIN(pin_vec), .SYNC(pins));
    dcbm_pin_sync #(.W(dcbm_pkg::DATA_W)) u_data_sync (
        .CLK(CLK), .SRST(SRST), .PIN(WRITE_DATA_IN), .SYNC(din));

    // configuration latched while master reset is held
    dcbm_pkg::dcbm_width_e in_w;
    dcbm_pkg::dcbm_width_e out_w;
    logic big_end;
    logic ft_mode;
    logic zero_lat_rt;
    logic sync_flags;
    logic async_wr;
    logic async_rd;
    logic master_reset_n;
    logic partial_reset_n;
    logic clear;

    assign master_reset_n = ~pins.level[dcbm_pkg::CTL_MRS_N];
    assign partial_reset_n = ~pins.level[dcbm_pkg::CTL_PRS_N];
    assign clear = SRST | master_reset_n | partial_reset_n;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            in_w <= dcbm_pkg::DCBM_W36;
            out_w <= dcbm_pkg::DCBM_W36;
            big_end <= 1'b0;
            ft_mode <= 1'b0;
            zero_lat_rt <= 1'b0;
            sync_flags <= 1'b0;
            async_wr <= 1'b0;
            async_rd <= 1'b0;
        end else if (master_reset_n) begin
            in_w <= dcbm_pkg::DCBM_W36;
            out_w <= dcbm_pkg::DCBM_W36;
            if (pins.level[dcbm_pkg::CTL_BM]) begin
                if (pins.level[dcbm_pkg::CTL_IW]) begin
                    in_w <= pins.level[dcbm_pkg::CTL_OW] ?
                        dcbm_pkg::DCBM_W9 : dcbm_pkg::DCBM_W18;
                end else begin
                    out_w <= pins.level[dcbm_pkg::CTL_OW] ?
                        dcbm_pkg::DCBM_W9 : dcbm_pkg::DCBM_W18;
                end
            end
            big_end <= pins.level[dcbm_pkg::CTL_BE];
            ft_mode <= pins.level[dcbm_pkg::CTL_FTSI];
            zero_lat_rt <= ~pins.level[dcbm_pkg::CTL_RM];
            sync_flags <= pins.level[dcbm_pkg::CTL_PFM];
            async_wr <= pins.level[dcbm_pkg::CTL_ASYW];
            async_rd <= pins.level[dcbm_pkg::CTL_ASYR];
        end
    end

    // last piece index for a given port width
    function automatic logic [1:0] last_idx(input dcbm_pkg::dcbm_width_e w);
        unique case (w)
            dcbm_pkg::DCBM_W36: last_idx = 2'h0;
            dcbm_pkg::DCBM_W18: last_idx = 2'h1;
            dcbm_pkg::DCBM_W9: last_idx = 2'h3;
            default: last_idx = 2'h0;
        endcase
    endfunction

    // bit offset of a piece inside the stored word
    function automatic int piece_sh(input dcbm_pkg::dcbm_width_e w,
        input logic [1:0] idx, input logic big);
        unique case (w)
            dcbm_pkg::DCBM_W18: piece_sh = big ? 18 * (1 - int'(idx)) :
                18 * int'(idx);
            dcbm_pkg::DCBM_W9: piece_sh = big ? 9 * (3 - int'(idx)) :
                9 * int'(idx);
            default: piece_sh = 0;
        endcase
    endfunction

    // piece of a stored word, narrow data in the low bits
    function automatic logic [35:0] get_piece(input logic [35:0] word,
        input dcbm_pkg::dcbm_width_e w, input logic [1:0] idx,
        input logic big);
        logic [35:0] sh;
        sh = word >> piece_sh(w, idx, big);
        unique case (w)
            dcbm_pkg::DCBM_W18: get_piece = {18'h00000, sh[17:0]};
            dcbm_pkg::DCBM_W9: get_piece = {27'h0000000, sh[8:0]};
            default: get_piece = word;
        endcase
    endfunction

    function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    function automatic logic [PW-1:0] to_bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        for (int i = PW - 1; i >= 0; i--) begin
            b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i + 1]);
        end
        to_bin = b;
    endfunction

    logic [35:0] mem [DEPTH];
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW-1:0] wptr_g;
    logic [PW-1:0] rptr_g;
    logic [PW-1:0] wg_s1;
    logic [PW-1:0] wg_s2;
    logic [PW-1:0] rg_s1;
    logic [PW-1:0] rg_s2;
    logic [PW-1:0] w_diff;
    logic [PW-1:0] r_diff;
    logic [CW-1:0] w_cnt;
    logic [CW-1:0] r_cnt;
    logic w_full;
    logic r_empty;

    // gray pointers through two stages into the other side
    always_ff @(posedge CLK) begin
        if (clear) begin
            wg_s1 <= '0;
            wg_s2 <= '0;
            rg_s1 <= '0;
            rg_s2 <= '0;
        end else begin
            wg_s1 <= wptr_g;
            wg_s2 <= wg_s1;
            rg_s1 <= rptr_g;
            rg_s2 <= rg_s1;
        end
    end

    assign wptr_g = to_gray(wptr);
    assign rptr_g = to_gray(rptr);
    assign w_diff = wptr - to_bin(rg_s2);
    assign r_diff = to_bin(wg_s2) - rptr;
    assign w_cnt = CW'(w_diff);
    assign r_cnt = CW'(r_diff);
    assign w_full = (w_cnt == CW'(DEPTH));
    assign r_empty = (r_cnt == '0);

    // write side: events, piece packing and offset loading
    logic w_tick;
    logic w_ev;
    logic loading;
    logic [1:0] wpc;
    logic [35:0] w_acc;
    logic [35:0] next_w_acc;
    logic [OW-1:0] ae_ofs;
    logic [OW-1:0] af_ofs;
    logic ofs_sel;

    assign w_tick = async_wr ? pins.rise[dcbm_pkg::EV_WR] :
        pins.rise[dcbm_pkg::EV_WCLK];
    assign w_ev = async_wr ? pins.rise[dcbm_pkg::EV_WR] :
        (pins.rise[dcbm_pkg::EV_WCLK] &
        ~pins.level[dcbm_pkg::CTL_WEN_N]);
    assign loading = ~pins.level[dcbm_pkg::CTL_LD_N];

    always_comb begin
        next_w_acc = w_acc;
        unique case (in_w)
            dcbm_pkg::DCBM_W18: next_w_acc[piece_sh(in_w, wpc, big_end) +: 18]
                = din.level[17:0];
            dcbm_pkg::DCBM_W9: next_w_acc[piece_sh(in_w, wpc, big_end) +: 9]
                = din.level[8:0];
            default: next_w_acc = din.level;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (clear) begin
            wptr <= '0;
            wpc <= 2'h0;
            w_acc <= '0;
        end else if (w_ev && !loading && !w_full) begin
            w_acc <= next_w_acc;
            if (wpc == last_idx(in_w)) begin
                wpc <= 2'h0;
                wptr <= wptr + 1'b1;
            end else begin
                wpc <= wpc + 2'h1;
            end
        end
    end

    // storage write, whole word once the last piece arrives
    always_ff @(posedge CLK) begin
        if (!clear && w_ev && !loading && !w_full &&
            wpc == last_idx(in_w)) begin
            mem[wptr[AW-1:0]] <= next_w_acc;
        end
    end

    // almost-flag offsets: presets at master reset, then loads
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ae_ofs <= dcbm_pkg::DEF_OFS[0];
            af_ofs <= dcbm_pkg::DEF_OFS[0];
            ofs_sel <= 1'b0;
        end else if (master_reset_n) begin
            ae_ofs <= dcbm_pkg::DEF_OFS[{pins.level[dcbm_pkg::CTL_FS1],
                pins.level[dcbm_pkg::CTL_FS0], loading}];
            af_ofs <= dcbm_pkg::DEF_OFS[{pins.level[dcbm_pkg::CTL_FS1],
                pins.level[dcbm_pkg::CTL_FS0], loading}];
            ofs_sel <= 1'b0;
        end else if (partial_reset_n) begin
            ofs_sel <= 1'b0;
        end else if (loading && w_ev) begin
            if (ofs_sel) begin
                af_ofs <= din.level[OW-1:0];
            end else begin
                ae_ofs <= din.level[OW-1:0];
            end
            ofs_sel <= ~ofs_sel;
        end else if (loading && w_tick &&
            !pins.level[dcbm_pkg::CTL_SEN_N]) begin
            {ae_ofs, af_ofs} <= {ae_ofs[OW-2:0], af_ofs,
                pins.level[dcbm_pkg::CTL_FTSI]};
        end
    end

    // read side: events, unpacking, fall-through and retransmit
    logic r_tick;
    logic r_ev;
    logic rt;
    logic out_valid;
    logic [1:0] ft_cnt;
    logic [1:0] rpc;
    logic ft_due;
    logic take;
    logic [35:0] head;

    assign r_tick = async_rd ? pins.rise[dcbm_pkg::EV_RD] :
        pins.rise[dcbm_pkg::EV_RCLK];
    assign r_ev = async_rd ? pins.rise[dcbm_pkg::EV_RD] :
        (pins.rise[dcbm_pkg::EV_RCLK] &
        ~pins.level[dcbm_pkg::CTL_REN_N]);
    assign rt = r_tick & ~pins.level[dcbm_pkg::CTL_RT_N];
    assign ft_due = r_tick && !r_empty &&
        (ft_cnt == dcbm_pkg::FT_RCLK_EDGES - 2'h1);
    assign head = mem[rptr[AW-1:0]];
    assign take = !r_empty && (ft_mode ?
        ((!out_valid && ft_due) || (out_valid && r_ev)) :
        r_ev);

    always_ff @(posedge CLK) begin
        if (clear) begin
            rptr <= '0;
            rpc <= 2'h0;
            READ_DATA_OUT <= dcbm_pkg::DOUT_RST;
        end else if (rt) begin
            READ_DATA_OUT <= zero_lat_rt ?
                get_piece(mem[0], out_w, 2'h0, big_end) : READ_DATA_OUT;
            rptr <= (zero_lat_rt && last_idx(out_w) == 2'h0) ?
                PW'(1) : '0;
            rpc <= (zero_lat_rt && last_idx(out_w) != 2'h0) ?
                2'h1 : 2'h0;
        end else if (take) begin
            READ_DATA_OUT <= get_piece(head, out_w, rpc, big_end);
            if (rpc == last_idx(out_w)) begin
                rpc <= 2'h0;
                rptr <= rptr + 1'b1;
            end else begin
                rpc <= rpc + 2'h1;
            end
        end
    end

    // fall-through output-valid state and edge counter
    always_ff @(posedge CLK) begin
        if (clear) begin
            out_valid <= 1'b0;
            ft_cnt <= 2'h0;
        end else if (rt) begin
            out_valid <= zero_lat_rt;
            ft_cnt <= 2'h0;
        end else if (!out_valid) begin
            if (r_empty) begin
                ft_cnt <= 2'h0;
            end else if (ft_due) begin
                out_valid <= ft_mode;
                ft_cnt <= 2'h0;
            end else if (r_tick) begin
                ft_cnt <= ft_cnt + 2'h1;
            end
        end else if (r_ev && r_empty) begin
            out_valid <= 1'b0;
        end
    end

    // status flags, almost flags gated by their own clock when sync_flags is set, else updated every cycle
    always_ff @(posedge CLK) begin
        if (clear) begin
            EMPTY_FLAG_N <= ft_mode;
            FULL_FLAG_N <= ~ft_mode;
            HALF_FULL_FLAG_N <= 1'b1;
            ALMOST_EMPTY_FLAG_N <= 1'b0;
            ALMOST_FULL_FLAG_N <= 1'b1;
        end else begin
            EMPTY_FLAG_N <= ft_mode ? ~out_valid : ~r_empty;
            FULL_FLAG_N <= ft_mode ? w_full : ~w_full;
            HALF_FULL_FLAG_N <= ~(w_cnt > CW'(DEPTH / 2));
            if (!sync_flags || r_tick) begin
                ALMOST_EMPTY_FLAG_N <= ~(r_cnt <= CW'(ae_ofs));
            end
            if (!sync_flags || w_tick) begin
                ALMOST_FULL_FLAG_N <= ~(w_cnt >= CW'(DEPTH) - CW'(af_ofs));
            end
        end
    end

    // data outputs driven only while output enable is low
    assign READ_DATA_OUT_OE = ~pins.level[dcbm_pkg::CTL_OE_N];
endmodule

// ==== verification/dcbm_link_model.sv ====
`timescale 1ns/10ps
// free-running write and read link clocks, 48 ns, read lags write
module dcbm_link_model (
    input wire logic CLK,
    output logic WRITE_CLK,
    output logic READ_CLK
);
    int cnt = 0;
    initial begin
        WRITE_CLK = 1'b0;
        READ_CLK = 1'b0;
    end
    // edges land on falling system clock edges, 6 cycles per half period
    always @(negedge CLK) begin
        cnt <= (cnt == 11) ? 0 : cnt + 1;
        WRITE_CLK <= (cnt < 6);
        READ_CLK <= ((cnt + 10) % 12 < 6);
    end
endmodule

// ==== verification/dcbm_fifo_monitor.sv ====
`timescale 1ns/10ps
module dcbm_fifo_monitor #(
    parameter int DEPTH = 16
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic WRITE_CLK,
    input wire logic READ_CLK,
    input wire logic WRITE_STROBE,
    input wire logic READ_STROBE,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic MASTER_RESET_N,
    input wire logic PARTIAL_RESET_N,
    input wire logic RETRANSMIT_N,
    input wire logic FALLTHROUGH_SEL_SERIAL_IN,
    input logic [35:0] READ_DATA_OUT,
    input logic READ_DATA_OUT_OE,
    input logic EMPTY_FLAG_N,
    input logic FULL_FLAG_N,
    input logic HALF_FULL_FLAG_N,
    input logic ALMOST_FULL_FLAG_N
);
    logic ft, wclk_d, rclk_d;
    logic [3:0] wr_age, rd_age;
    logic wstb_d, rstb_d, w_rise, r_rise;
    // a port event is a link clock rise or a strobe rise
    assign w_rise = (WRITE_CLK && !wclk_d) || (WRITE_STROBE && !wstb_d);
    assign r_rise = (READ_CLK && !rclk_d) || (READ_STROBE && !rstb_d);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // timing mode follows the pin while master reset is low
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ft <= 1'b0;
        end else if (!MASTER_RESET_N) begin
            ft <= FALLTHROUGH_SEL_SERIAL_IN;
        end
    end
    // cycles since the latest link clock or strobe rises, saturating
    always_ff @(posedge CLK) begin
        wclk_d <= WRITE_CLK;
        rclk_d <= READ_CLK;
        wstb_d <= WRITE_STROBE;
        rstb_d <= READ_STROBE;
        if (SRST || w_rise) begin
            wr_age <= SRST ? 4'hf : 4'h0;
        end else if (wr_age != 4'hf) begin
            wr_age <= wr_age + 4'h1;
        end
        if (SRST || r_rise) begin
            rd_age <= SRST ? 4'hf : 4'h0;
        end else if (rd_age != 4'hf) begin
            rd_age <= rd_age + 4'h1;
        end
    end
    oe_on_a: assert property (
        $fell(OUTPUT_ENABLE_N) |-> ##[1:4] READ_DATA_OUT_OE)
        else $error("outputs not driven");
    oe_off_a: assert property (
        OUTPUT_ENABLE_N[*5] |-> !READ_DATA_OUT_OE)
        else $error("outputs driven while disabled");
    full_hf_a: assert property (
        !ft && !FULL_FLAG_N |-> !HALF_FULL_FLAG_N)
        else $error("full without half full");
    prst_clear_a: assert property (
        (!ft && !PARTIAL_RESET_N)[*4] |->
        !EMPTY_FLAG_N && FULL_FLAG_N && HALF_FULL_FLAG_N)
        else $error("flags not reset by partial reset");
    mrst_clear_a: assert property (
        (!MASTER_RESET_N)[*4] |-> READ_DATA_OUT == dcbm_pkg::DOUT_RST)
        else $error("data not cleared by master reset");
    std_out_a: assert property (
        !ft && MASTER_RESET_N && PARTIAL_RESET_N &&
        $past(MASTER_RESET_N, 4) && $past(PARTIAL_RESET_N, 4) &&
        $changed(READ_DATA_OUT) |-> rd_age <= 4'h6)
        else $error("output changed without a read");
    ef_rise_a: assert property (
        !ft && $rose(EMPTY_FLAG_N) |-> wr_age <= 4'hc || rd_age <= 4'hc)
        else $error("empty flag left without a write");
    ff_fall_a: assert property (
        !ft && $fell(FULL_FLAG_N) |-> wr_age <= 4'hc)
        else $error("full flag without a write");
    empty_hold_a: assert property (
        (!ft && !EMPTY_FLAG_N && RETRANSMIT_N && MASTER_RESET_N &&
        PARTIAL_RESET_N)[*8] |-> $stable(READ_DATA_OUT))
        else $error("read taken while empty");
    af_full_a: assert property (
        !ft && $fell(FULL_FLAG_N) |-> ##[0:16] !ALMOST_FULL_FLAG_N)
        else $error("almost full missing at full");
    cover property ($fell(FULL_FLAG_N));
    cover property (!RETRANSMIT_N && READ_CLK && !rclk_d);
    cover property (ft && $fell(EMPTY_FLAG_N));
endmodule
bind dcbm_fifo dcbm_fifo_monitor #(.DEPTH(DEPTH)) u_mon (.*);

// ==== verification/tb.sv ====
`timescale 1ns/10ps
module tb;
    localparam int DEPTH = 16;
    logic CLK, SRST, WRITE_CLK, READ_CLK, WRITE_STROBE, READ_STROBE;
    logic WRITE_ENABLE_N, READ_ENABLE_N, OUTPUT_ENABLE_N, MASTER_RESET_N;
    logic PARTIAL_RESET_N, RETRANSMIT_N, RETRANSMIT_LATENCY_SEL, LOAD_N;
    logic FLAG_TIMING_SEL, INPUT_WIDTH_SEL, OUTPUT_WIDTH_SEL, FLAG_SEL0;
    logic BUS_MATCHING_SEL, BIG_ENDIAN_SEL, FALLTHROUGH_SEL_SERIAL_IN;
    logic SERIAL_ENABLE_N, FLAG_SEL1, ASYNC_WRITE_SEL, ASYNC_READ_SEL;
    logic READ_DATA_OUT_OE, EMPTY_FLAG_N, FULL_FLAG_N, HALF_FULL_FLAG_N;
    logic ALMOST_EMPTY_FLAG_N, ALMOST_FULL_FLAG_N, big;
    logic [35:0] WRITE_DATA_IN, READ_DATA_OUT;
    logic [35:0] words [DEPTH];
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    int ni, no;
    dcbm_fifo #(.DEPTH(DEPTH)) u_dut (.*);
    dcbm_link_model u_link (.*);
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    // cut a hang short
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(negedge CLK);
    endtask
    // piece i of n of a word, in port order for the chosen endianness
    function automatic logic [35:0] piece(input logic [35:0] w, input int n,
            input int i, input logic be);
        int k;
        k = be ? n - 1 - i : i;
        return (w >> (k * (36 / n))) & ((36'h1 << (36 / n)) - 36'h1);
    endfunction
    task automatic wr(input logic [35:0] d);
        @(negedge WRITE_CLK);
        WRITE_ENABLE_N = 1'b0;
        WRITE_DATA_IN = d;
        @(posedge WRITE_CLK);
    endtask
    task automatic wr_end();
        @(negedge WRITE_CLK);
        WRITE_ENABLE_N = 1'b1;
    endtask
    task automatic rd(input logic [35:0] exp);
        @(negedge READ_CLK);
        READ_ENABLE_N = 1'b0;
        @(posedge READ_CLK);
        wait_clk(5);
        chk(READ_DATA_OUT, exp);
    endtask
    // one strobe pulse, wide enough for the pin sampler
    task automatic stb(input logic rd_side);
        wait_clk(4);
        if (rd_side) begin
            READ_STROBE = 1'b1;
        end else begin
            WRITE_STROBE = 1'b1;
        end
        wait_clk(4);
        {WRITE_STROBE, READ_STROBE} = 2'h0;
    endtask
    task automatic rd_end();
        @(negedge READ_CLK);
        READ_ENABLE_N = 1'b1;
    endtask
    // config bits: width match, in width, out width, endian, mode, latency
    task automatic mreset(input logic [5:0] c);
        @(negedge CLK);
        {BUS_MATCHING_SEL, INPUT_WIDTH_SEL, OUTPUT_WIDTH_SEL, BIG_ENDIAN_SEL,
            FALLTHROUGH_SEL_SERIAL_IN, RETRANSMIT_LATENCY_SEL} = c;
        FLAG_TIMING_SEL = 1'($urandom_range(1));
        LOAD_N = 1'b0;
        MASTER_RESET_N = 1'b0;
        wait_clk(6);
        MASTER_RESET_N = 1'b1;
        wait_clk(5);
        LOAD_N = 1'b1;
        wait_clk(4);
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h6885f200));
        {WRITE_STROBE, READ_STROBE, ASYNC_WRITE_SEL, ASYNC_READ_SEL} = 4'h0;
        {SERIAL_ENABLE_N, WRITE_ENABLE_N, READ_ENABLE_N} = 3'h7;
        {MASTER_RESET_N, PARTIAL_RESET_N, RETRANSMIT_N, LOAD_N} = 4'hf;
        {FLAG_SEL0, FLAG_SEL1, OUTPUT_ENABLE_N, FLAG_TIMING_SEL} = 4'h0;
        {BUS_MATCHING_SEL, INPUT_WIDTH_SEL, OUTPUT_WIDTH_SEL} = 3'h0;
        {BIG_ENDIAN_SEL, FALLTHROUGH_SEL_SERIAL_IN} = 2'h0;
        RETRANSMIT_LATENCY_SEL = 1'b1;
        WRITE_DATA_IN = 36'h0;
        SRST = 1'b1;
        wait_clk(2);
        SRST = 1'b0;
        wait_clk(4);
        chk({EMPTY_FLAG_N, FULL_FLAG_N, HALF_FULL_FLAG_N, ALMOST_EMPTY_FLAG_N,
            ALMOST_FULL_FLAG_N}, 36'h0d);
        // every width pairing, two words each way, random endianness
        for (int m = 0; m < 5; m++) begin
            ni = (m == 3) ? 2 : (m == 4) ? 4 : 1;
            no = (m == 1) ? 2 : (m == 2) ? 4 : 1;
            big = 1'($urandom_range(1));
            mreset({m != 0, m > 2, m == 2 || m == 4, big, 2'b01});
            chk(READ_DATA_OUT, 36'h0);
            for (int w = 0; w < 2; w++) begin
                words[w] = 36'({$urandom(), $urandom()});
                for (int i = 0; i < ni; i++) begin
                    wr(piece(words[w], ni, i, big));
                end
            end
            wr_end();
            wait_clk(16);
            chk(READ_DATA_OUT, 36'h0);
            for (int w = 0; w < 2; w++) begin
                for (int i = 0; i < no; i++) begin
                    rd(piece(words[w], no, i, big));
                end
            end
            rd_end();
        end
        // fill to full, one refused write, drain, one refused read
        mreset(6'h01);
        for (int w = 0; w < DEPTH; w++) begin
            words[w] = 36'({$urandom(), $urandom()});
            wr(words[w]);
            if (w == 6) begin
                wr_end();
                wait_clk(16);
                chk(ALMOST_EMPTY_FLAG_N, 36'h0);
            end
        end
        wr(36'h0);
        wr_end();
        wait_clk(16);
        chk({FULL_FLAG_N, HALF_FULL_FLAG_N, ALMOST_FULL_FLAG_N},
            36'h0);
        for (int w = 0; w < DEPTH; w++) rd(words[w]);
        rd(words[DEPTH-1]);
        rd_end();
        wait_clk(16);
        chk(EMPTY_FLAG_N, 36'h0);
        // rewind with zero and normal latency
        for (int rm = 0; rm < 2; rm++) begin
            mreset({5'h0, rm[0]});
            for (int w = 0; w < 3; w++) wr(words[w]);
            wr_end();
            wait_clk(16);
            for (int w = 0; w < 3; w++) rd(words[w]);
            @(negedge READ_CLK);
            READ_ENABLE_N = 1'b1;
            RETRANSMIT_N = 1'b0;
            @(negedge READ_CLK);
            RETRANSMIT_N = 1'b1;
            wait_clk(4);
            chk(READ_DATA_OUT, words[rm == 0 ? 0 : 2]);
            for (int w = 1 - rm; w < 3; w++) rd(words[w]);
            rd_end();
        end
        // parallel offsets 3 and 2 loaded, almost-empty offset 3 checked after a partial reset
        mreset(6'h01);
        LOAD_N = 1'b0;
        wr(36'h3);
        wr(36'h2);
        wr_end();
        wait_clk(2);
        LOAD_N = 1'b1;
        PARTIAL_RESET_N = 1'b0;
        wait_clk(6);
        PARTIAL_RESET_N = 1'b1;
        wait_clk(6);
        for (int w = 0; w < 4; w++) begin
            wr(words[w]);
            if (w == 2) begin
                wr_end();
                wait_clk(16);
                chk(ALMOST_EMPTY_FLAG_N, 36'h0);
            end
        end
        wr_end();
        wait_clk(16);
        chk(ALMOST_EMPTY_FLAG_N, 36'h1);
        // strobe ports, standard mode, enables held low throughout
        {ASYNC_WRITE_SEL, ASYNC_READ_SEL} = 2'h3;
        mreset(6'h01);
        {WRITE_ENABLE_N, READ_ENABLE_N} = 2'h0;
        for (int w = 0; w < 2; w++) begin
            WRITE_DATA_IN = words[w];
            stb(1'b0);
        end
        for (int w = 0; w < 2; w++) begin
            stb(1'b1);
            chk(READ_DATA_OUT, words[w]);
        end
        wait_clk(4);
        chk(EMPTY_FLAG_N, 36'h0);
        {WRITE_ENABLE_N, READ_ENABLE_N} = 2'h3;
        {ASYNC_WRITE_SEL, ASYNC_READ_SEL} = 2'h0;
        // fall-through: first word appears with no read
        mreset(6'h03);
        wr(words[5]);
        wr_end();
        wait_clk(60);
        chk(READ_DATA_OUT, words[5]);
        chk(EMPTY_FLAG_N, 36'h0);
        OUTPUT_ENABLE_N = 1'b1;
        wait_clk(6);
        chk(READ_DATA_OUT_OE, 36'h0);
        OUTPUT_ENABLE_N = 1'b0;
        wait_clk(6);
        chk(READ_DATA_OUT_OE, 36'h1);
        wrap_up();
    end
endmodule
